/* del_detector_livetime.sv */
// event state machines, nap and veto control, live-time counters, register slave
// Notes on behaviour
// (R1) 20-bit live-time counter, cleared each second
// (R2) dead-time low stops live-time counting
// (R3) busy-wait also stops live-time counting
// (R4) upper 8 bits captured each second
// (R5) counter freezes when upper 12 bits set
// (R6) combined inhibit gates 2 kHz counter
// (R7) priority: event, then reset, then over-threshold
// (R8) request held, arrivals ignored until done
// (R9) busy only on arrival while awaiting done
// (R10) each event type disabled by its enable; energy events also by veto
// (R11) latch time and adjusted inverted energy
// (R12) separate service-time latch for other cycles
// (R13) event strobe acts on rising edge only
// (R14) nap output raised by start, dropped by strobe
// (R15) veto captures discriminator on valid fall
// (R16) veto blocks strobe, clears on nap
// (R17) 9-bit counter gated by both inhibits
// (R18) 9-bit counter latched, cleared every 512 ticks
// (R19) three nibbles after tick, then zeros
// (R20) latch frozen once first nibble read
// (R21) tick overwrites unread or fully-sent latch
// (R22) front-end pulses synchronised, edges registered
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module del_detector_livetime import del_pkg::*; #(
	parameter int SECOND_TICKS = SECOND_US
) (
	input  wire logic                          core_clk,
	input  wire logic                          resetn,
	input  wire logic [ADDR_W-1:0]             awaddr,
	input  wire logic                          awvalid,
	output logic                               awready,
	input  wire logic [31:0]                   wdata,
	input  wire logic [3:0]                    wstrb,
	input  wire logic                          wvalid,
	output logic                               wready,
	output logic [1:0]                         bresp,
	output logic                               bvalid,
	input  wire logic                          bready,
	input  wire logic [ADDR_W-1:0]             araddr,
	input  wire logic                          arvalid,
	output logic                               arready,
	output logic [31:0]                        rdata,
	output logic [1:0]                         rresp,
	output logic                               rvalid,
	input  wire logic                          rready,
	input  wire logic [NDET-1:0]               frontEndLive,
	input  wire logic [NDET-1:0]               startDisc,
	input  wire logic [NDET-1:0]               eventStrobe,
	input  wire logic [NDET-1:0]               chargeAmpResetN,
	input  wire logic [NDET-1:0]               overLimitN,
	input  wire logic [NDET-1:0]               slowValidN,
	input  wire logic [NDET-1:0]               upperLevelN,
	input  wire logic [NDET-1:0][ADC_W-1:0]    adcData,
	input  wire logic [NDET-1:0][DITHER_W-1:0] ditherOffset,
	input  wire logic [TS_W-1:0]               timeStamp,
	input  wire logic [NDET-1:0]               xferDone,
	output logic [NDET-1:0]                    xferReq,
	output del_cycle_type [NDET-1:0]           cycleType,
	output logic [NDET-1:0][TS_W-1:0]          eventTime,
	output logic [NDET-1:0][ADC_W-1:0]         eventEnergy,
	output logic [NDET-1:0][TS_W-1:0]          serviceTime,
	output logic [NDET-1:0]                    adcNapCtl,
	output logic [NDET-1:0]                    busyWait,
	output logic [NDET-1:0][NIB_W-1:0]         livetimeNibble
);
	// ************************************************************
	// functions
	// ************************************************************
	// converter word plus dither, low bits inverted
	function automatic logic [ADC_W-1:0] adjustEnergy(
		input logic [ADC_W-1:0] raw, input logic [DITHER_W-1:0] dith);
		logic [ADC_W-1:0] sum;
		sum = raw + ADC_W'(dith);
		return sum ^ {1'b0, {INV_W{1'b1}}};
	endfunction : adjustEnergy

	// nibble shown for the number already sent
	function automatic logic [NIB_W-1:0] nibbleOf(
		input logic [1:0] sent, input logic [DLT_W-1:0] val);
		case (sent)
			2'h0:    return {1'b1, val[8:6]};
			2'h1:    return {1'b0, val[5:3]};
			2'h2:    return {1'b0, val[2:0]};
			default: return '0;
		endcase
	endfunction : nibbleOf

	// true when the byte address selects the given register word
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		return a[ADDR_W-1:2] == off[ADDR_W-1:2];
	endfunction : hit

	// ************************************************************
	// input synchronisers
	// ************************************************************
	logic [6*NDET-1:0] pulseLvl, pulseRise, pulseFall;  // synced controls
	logic [NDET*ADC_W-1:0] adcSync;                      // synced data
	del_sync_edge #(.W(6*NDET)) u_sync_pulse (  // R22
		.core_clk (core_clk),
		.resetn   (resetn),
		.asyncIn  ({frontEndLive, startDisc, eventStrobe,
		            chargeAmpResetN, overLimitN, slowValidN}),
		.level    (pulseLvl),
		.rise     (pulseRise),
		.fall     (pulseFall)
	);
	del_sync_edge #(.W(NDET*ADC_W)) u_sync_adc (
		.core_clk (core_clk),
		.resetn   (resetn),
		.asyncIn  (adcData),
		.level    (adcSync),
		.rise     (),
		.fall     ()
	);
	logic [NDET-1:0] uldSync1, uldSync;  // discriminator level, two stages
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			uldSync1 <= '0;
			uldSync  <= '0;
		end else begin
			uldSync1 <= ~upperLevelN;
			uldSync  <= uldSync1;
		end
	end

	logic [NDET-1:0] liveOk, startRise, strobeRise, csaFall, ovrFall, validFall;
	assign liveOk     = pulseLvl[6*NDET-1 -: NDET];
	assign startRise  = pulseRise[5*NDET-1 -: NDET];
	assign strobeRise = pulseRise[4*NDET-1 -: NDET];  // R13
	assign csaFall    = pulseFall[3*NDET-1 -: NDET];
	assign ovrFall    = pulseFall[2*NDET-1 -: NDET];
	assign validFall  = pulseFall[NDET-1 -: NDET];

	// ************************************************************
	// tick dividers
	// ************************************************************
	logic [TICK_W-1:0] divCnt;   // core cycles within a microsecond
	logic [SEC_W-1:0]  usCnt;    // microseconds within a second
	logic [TWOK_W-1:0] twoKCnt;  // microseconds within a 2 kHz period
	logic oneMhzTick, oneSecTick, twoKTick;
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			divCnt     <= '0;
			oneMhzTick <= 1'b0;
		end else begin
			oneMhzTick <= (divCnt == TICK_W'(TICK_DIV - 1));
			divCnt <= (divCnt == TICK_W'(TICK_DIV - 1)) ? '0 : divCnt + 1'b1;
		end
	end

	// second and 2 kHz ticks; the second restarts the 2 kHz phase
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			usCnt      <= '0;
			twoKCnt    <= '0;
			oneSecTick <= 1'b0;
			twoKTick   <= 1'b0;
		end else begin
			oneSecTick <= 1'b0;
			twoKTick   <= 1'b0;
			if (oneMhzTick) begin
				if (usCnt == SEC_W'(SECOND_TICKS - 1)) begin
					usCnt      <= '0;
					twoKCnt    <= '0;
					oneSecTick <= 1'b1;
					twoKTick   <= 1'b1;  // R18
				end else begin
					usCnt    <= usCnt + 1'b1;
					twoKCnt  <= twoKCnt + 1'b1;
					twoKTick <= (twoKCnt == '1);  // R18
				end
			end
		end
	end

	// ************************************************************
	// register file
	// ************************************************************
	logic [7:0] ctrlReg;               // event enables per detector
	logic [NDET-1:0][HOLD_W-1:0] ltHold;  // captured live time
	logic [NDET-1:0] veto;             // event veto flags
	del_event_state_machine_type [NDET-1:0] state;    // event machines
	logic [ADDR_W-1:0] awAddrQ;        // held write address
	logic [31:0] wDataQ;               // held write data
	logic [3:0]  wStrbQ;               // held strobes

	// write channel: address and data taken in either order
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			awAddrQ <= '0;
			wDataQ  <= '0;
			wStrbQ  <= '0;
			ctrlReg <= CTRL_RESET;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				awAddrQ <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				wDataQ <= wdata;
				wStrbQ <= wstrb;
			end
			if (!awready && !wready && !bvalid) begin
				bvalid <= 1'b1;
				// read-only words accept and ignore writes
				if (hit(awAddrQ, REG_CTRL)) begin
					bresp <= RESP_OKAY;
					if (wStrbQ[0])
						ctrlReg <= wDataQ[7:0];
				end else if (hit(awAddrQ, REG_LIVE) || hit(awAddrQ, REG_STAT))
					bresp <= RESP_OKAY;
				else
					bresp <= RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// read channel: one answer per address, unmapped words error
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= RESP_OKAY;
			if (hit(araddr, REG_CTRL))
				rdata <= {24'h0, ctrlReg};
			else if (hit(araddr, REG_LIVE))
				rdata <= {16'h0, ltHold[1], ltHold[0]};  // R4
			else if (hit(araddr, REG_STAT))
				rdata <= {24'h0, veto[1], adcNapCtl[1], busyWait[1],
					state[1] == ST_WAIT, veto[0], adcNapCtl[0], busyWait[0],
					state[0] == ST_WAIT};
			else begin
				rdata <= '0;
				rresp <= RESP_SLVERR;
			end
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ************************************************************
	// nap control and event veto
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			adcNapCtl <= '0;
			veto      <= '0;
		end else begin
			for (int d = 0; d < NDET; d++) begin
				// a strobe edge ends the conversion, so it wins
				if (strobeRise[d])
					adcNapCtl[d] <= 1'b0;  // R14
				else if (startRise[d])
					adcNapCtl[d] <= 1'b1;  // R14
				if (!adcNapCtl[d])
					veto[d] <= 1'b0;  // R16
				else if (validFall[d])
					veto[d] <= uldSync[d];  // R15
			end
		end
	end

	// ************************************************************
	// event state machines
	// ************************************************************
	logic [NDET-1:0][2:0] arrive;   // qualified arrivals {ovr, csa, evt}
	logic [NDET-1:0][2:0] pend;     // simultaneous arrivals still to serve
	logic [NDET-1:0][2:0] collect;  // pending plus new in idle
	always_comb begin
		for (int d = 0; d < NDET; d++) begin
			arrive[d][0] = strobeRise[d] & ~veto[d]                 // R16
				& ctrlReg[d*EN_STRIDE + EN_EVT];                    // R10
			arrive[d][1] = csaFall[d] & ctrlReg[d*EN_STRIDE + EN_CSA];  // R10
			arrive[d][2] = ovrFall[d] & ctrlReg[d*EN_STRIDE + EN_OVR];  // R10
			collect[d]   = pend[d] | arrive[d];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state       <= {NDET{ST_IDLE}};
			pend        <= '0;
			cycleType   <= {NDET{CYC_NONE}};
			xferReq     <= '0;
			busyWait    <= '0;
			eventTime   <= '0;
			eventEnergy <= '0;
			serviceTime <= '0;
		end else begin
			for (int d = 0; d < NDET; d++) begin
				unique case (state[d])
					ST_IDLE: begin
						if (|collect[d]) begin
							state[d]   <= ST_WAIT;
							xferReq[d] <= 1'b1;  // R8
							if (collect[d][0]) begin  // R7
								cycleType[d]   <= CYC_EVENT;
								pend[d]        <= collect[d] & 3'b110;
								eventTime[d]   <= timeStamp;  // R11
								eventEnergy[d] <= adjustEnergy(adcSync[d*ADC_W +: ADC_W],
									ditherOffset[d]);  // R11
							end else if (collect[d][1]) begin  // R7
								cycleType[d]   <= CYC_CSA;
								pend[d]        <= collect[d] & 3'b100;
								serviceTime[d] <= timeStamp;  // R12
							end else begin
								cycleType[d]   <= CYC_OVR;
								pend[d]        <= '0;
								serviceTime[d] <= timeStamp;  // R12
							end
						end
					end
					ST_WAIT: begin
						// arrivals are dropped here; only busy remembers them
						if (xferDone[d]) begin
							state[d]   <= ST_IDLE;
							xferReq[d] <= 1'b0;
						end
						if (|arrive[d])
							busyWait[d] <= 1'b1;  // R9
						else if (xferDone[d])
							busyWait[d] <= 1'b0;
					end
				endcase
			end
		end
	end

	// ************************************************************
	// live-time counters
	// ************************************************************
	logic [NDET-1:0][LT_W-1:0]  ltCnt;    // one-second counters
	logic [NDET-1:0][DLT_W-1:0] dltCnt;   // 2 kHz counters
	logic [NDET-1:0][DLT_W-1:0] dltHold;  // value being telemetered
	logic [NDET-1:0][1:0]       nibSent;  // nibbles already read out
	logic [NDET-1:0] inhibit, wordRead, reload;
	always_comb begin
		for (int d = 0; d < NDET; d++) begin
			inhibit[d]  = ~liveOk[d] | busyWait[d];  // R2 R3
			wordRead[d] = xferDone[d] & (state[d] == ST_WAIT)
				& (cycleType[d] == CYC_EVENT);
			reload[d]   = twoKTick & (((nibSent[d] == 2'h0) & ~wordRead[d])
				| (nibSent[d] == NIB_IDLE));  // R21
		end
	end

	// one-second counters: capture, clear, freeze
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ltCnt  <= '0;
			ltHold <= '0;
		end else begin
			for (int d = 0; d < NDET; d++) begin
				if (oneSecTick) begin
					ltHold[d] <= ltCnt[d][LT_W-1 -: HOLD_W];  // R4
					ltCnt[d]  <= '0;  // R1
				end else if (oneMhzTick && !inhibit[d]  // R2 R3
					&& ltCnt[d][LT_W-1 -: SAT_W] != LT_SAT)  // R5
					ltCnt[d] <= ltCnt[d] + 1'b1;  // R1
			end
		end
	end

	// 2 kHz counters and nibble sequencing
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			dltCnt         <= '0;
			dltHold        <= '0;
			nibSent        <= {NDET{NIB_IDLE}};
			livetimeNibble <= '0;
		end else begin
			for (int d = 0; d < NDET; d++) begin
				if (twoKTick)
					dltCnt[d] <= '0;  // R18
				else if (oneMhzTick && !inhibit[d])  // R6 R17
					dltCnt[d] <= dltCnt[d] + 1'b1;
				if (reload[d]) begin
					dltHold[d] <= dltCnt[d];  // R18 R21
					nibSent[d] <= 2'h0;
				end else if (wordRead[d] && nibSent[d] != NIB_IDLE)
					nibSent[d] <= nibSent[d] + 1'b1;  // R20
				livetimeNibble[d] <= nibbleOf(nibSent[d], dltHold[d]);  // R19
			end
		end
	end

	// ************************************************************
	// assertions and covers, front detector
	// ************************************************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	chk_lt_clear: assert property (oneSecTick |=> ltCnt[0] == '0)  // R1
		else $error("live-time counter not cleared at second");
	chk_dead_stop: assert property (!liveOk[0] && !oneSecTick |=> $stable(ltCnt[0]))  // R2
		else $error("live-time counted while front end dead");
	chk_busy_stop: assert property (busyWait[0] && !oneSecTick |=> $stable(ltCnt[0]))  // R3
		else $error("live-time counted while busy");
	chk_hold_capture: assert property (oneSecTick |=> ltHold[0] == $past(ltCnt[0][19:12]))  // R4
		else $error("held live time wrong");
	chk_lt_freeze: assert property (ltCnt[0][19:8] == LT_SAT && !oneSecTick
		|=> ltCnt[0] == $past(ltCnt[0]))  // R5
		else $error("saturated counter moved");
	chk_evt_first: assert property (state[0] == ST_IDLE && arrive[0][0] && arrive[0][1]
		|=> cycleType[0] == CYC_EVENT ##1 pend[0][1])  // R7
		else $error("event not served first");
	chk_req_hold: assert property (xferReq[0] && !xferDone[0] |=> xferReq[0])  // R8
		else $error("request dropped before done");
	chk_busy_cause: assert property ($rose(busyWait[0]) |-> $past(state[0]) == ST_WAIT)  // R9
		else $error("busy without pending transfer");
	chk_energy_latch: assert property (state[0] == ST_IDLE && arrive[0][0]
		|=> eventEnergy[0] == (($past(adcSync[12:0])
			+ 13'($past(ditherOffset[0]))) ^ 13'h0FFF))  // R11
		else $error("energy latch wrong");
	chk_nap_wake: assert property (startRise[0] && !strobeRise[0] |=> adcNapCtl[0])  // R14
		else $error("nap output not raised");
	chk_veto_block: assert property (veto[0] && strobeRise[0] |=> $stable(eventTime[0]))  // R16
		else $error("vetoed strobe reached machine");
	chk_dlt_clear: assert property (twoKTick |=> dltCnt[0] == '0)  // R18
		else $error("2 kHz counter not cleared");
	chk_nib_marker: assert property (reload[0] && !xferDone[0]
		|=> ##1 livetimeNibble[0] == {1'b1, $past(dltCnt[0][8:6], 2)})  // R19
		else $error("first nibble wrong");

	cov_event_xfer: cover property (arrive[0][0] ##[1:40] xferDone[0]);
	cov_busy: cover property ($rose(busyWait[0]));
	cov_veto: cover property ($rose(veto[0]));
	cov_lt_sat: cover property (ltCnt[0][19:8] == LT_SAT);
endmodule : del_detector_livetime

/* del_pkg.sv */
// constants and types shared by the detector event and live-time block
package del_pkg;
	// ************************************************************
	// clocking and tick rates
	// ************************************************************
	localparam int CLK_HZ    = 40_000_000;        // core clock rate
	localparam int TICK_HZ   = 1_000_000;         // live-time tick rate
	localparam int TICK_DIV  = CLK_HZ / TICK_HZ;  // core cycles per tick
	localparam int TICK_W    = 6;                 // divider width
	localparam int SECOND_US = 1_000_000;         // one second in ticks
	localparam int SEC_W     = 20;                // second counter width
	localparam int TWOK_W    = 9;                 // 512 ticks per 2 kHz tick

	// ************************************************************
	// data widths
	// ************************************************************
	localparam int NDET     = 2;   // index 0 front, 1 rear
	localparam int LT_W     = 20;  // one-second live-time counter
	localparam int HOLD_W   = 8;   // captured upper bits
	localparam int SAT_W    = 12;  // bits that freeze the counter
	localparam int DLT_W    = 9;   // 2 kHz live-time counter
	localparam int ADC_W    = 13;  // converter word
	localparam int INV_W    = 12;  // low bits inverted by the latch
	localparam int DITHER_W = 6;   // dither offset
	localparam int TS_W     = 10;  // time stamp
	localparam int NIB_W    = 4;   // live-time nibble
	localparam logic [SAT_W-1:0] LT_SAT = 12'hFFF;
	localparam logic [1:0] NIB_IDLE = 2'h3;  // all three nibbles sent

	// ************************************************************
	// register map
	// ************************************************************
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;  // event enables
	localparam logic [ADDR_W-1:0] REG_LIVE = 8'h04;  // captured live time
	localparam logic [ADDR_W-1:0] REG_STAT = 8'h08;  // block state
	localparam logic [7:0] CTRL_RESET = 8'h77;
	localparam int EN_EVT    = 0;  // energy event enable
	localparam int EN_CSA    = 1;  // charge amplifier reset enable
	localparam int EN_OVR    = 2;  // over-threshold enable
	localparam int EN_STRIDE = 4;  // field spacing per detector
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ************************************************************
	// enumerations
	// ************************************************************
	typedef enum logic [1:0] {
		CYC_NONE  = 2'h0,
		CYC_EVENT = 2'h1,
		CYC_CSA   = 2'h2,
		CYC_OVR   = 2'h3
	} del_cycle_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} del_event_state_machine_type;
endpackage : del_pkg

/* del_sync_edge.sv */
// two-stage synchroniser with registered edge detection
`timescale 1ns/1ps
module del_sync_edge #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] stage1;  // metastable stage, read only by stage2
	logic [W-1:0] stage2;  // settled copy
	logic [W-1:0] prev;    // one cycle older, for edges

	// ************************************************************
	// synchroniser and edge registers
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			stage1 <= '0;
			stage2 <= '0;
			prev   <= '0;
		end else begin
			stage1 <= asyncIn;
			stage2 <= stage1;
			prev   <= stage2;
		end
	end

	// edges come from settled stages only
	assign level = stage2;
	assign rise  = stage2 & ~prev;
	assign fall  = ~stage2 & prev;
endmodule : del_sync_edge

/* del_xfer_partner.sv */
// transfer controller stand-in that answers event requests with done pulses
`timescale 1ns/1ps
module del_xfer_partner import del_pkg::*; (
	input  wire logic            core_clk,
	input  wire logic            resetn,
	input  wire logic [NDET-1:0] xferReq,
	input  wire logic [7:0]      lag,
	output logic      [NDET-1:0] xferDone
);
	logic [NDET-1:0][7:0] waitCnt; // cycles since the request was seen
	// one done per request after lag cycles; a long lag lets arrivals land while the request waits
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < NDET; i++) begin
			xferDone[i] <= resetn && xferReq[i] && (waitCnt[i] == lag);
			if (!resetn || !xferReq[i]) begin
				waitCnt[i] <= 8'h00;
			end else if (waitCnt[i] != 8'hFF) begin
				waitCnt[i] <= waitCnt[i] + 8'h01; // saturate, never a second done
			end
		end
	end
endmodule : del_xfer_partner

/* detector_event_livetime_tb_top.sv */
// self-checking bench for the detector event and live-time block
`timescale 1ns/1ps
module detector_event_livetime_tb_top import del_pkg::*;;
	logic core_clk = 1'b0, resetn = 1'b0;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic [NDET-1:0] frontEndLive, startDisc, eventStrobe, chargeAmpResetN, overLimitN;
	logic [NDET-1:0] slowValidN, upperLevelN, xferDone, xferReq, adcNapCtl, busyWait;
	logic [NDET-1:0][ADC_W-1:0] adcData, eventEnergy;
	logic [NDET-1:0][DITHER_W-1:0] ditherOffset;
	logic [TS_W-1:0] timeStamp = '0;
	logic [NDET-1:0][TS_W-1:0] eventTime, serviceTime;
	del_cycle_type [NDET-1:0] cycleType;
	logic [NDET-1:0][NIB_W-1:0] livetimeNibble;
	logic [7:0] lag;  // partner answer delay
	logic [31:0] rd;  // last read word
	int numErrors = 0, totalChecks = 0, cycles = 0;

	del_detector_livetime #(.SECOND_TICKS(1024)) uut (.core_clk, .resetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .frontEndLive, .startDisc,
		.eventStrobe, .chargeAmpResetN, .overLimitN, .slowValidN, .upperLevelN, .adcData,
		.ditherOffset, .timeStamp, .xferDone, .xferReq, .cycleType, .eventTime,
		.eventEnergy, .serviceTime, .adcNapCtl, .busyWait, .livetimeNibble);
	del_xfer_partner partner (.core_clk, .resetn, .xferReq, .lag, .xferDone);

	// ************************************************************
	// clock, time stamp and hang guard
	// ************************************************************
	initial forever #12.5 core_clk = ~core_clk;
	// the run needs about 41100 cycles; waiting for the first second tick dominates
	always @(posedge core_clk) begin
		timeStamp <= timeStamp + 10'h001;
		cycles <= cycles + 1;
		if (cycles == 50000) begin
			numErrors++;
			conclude();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	task automatic waitReq(input int d, input logic want);
		for (int i = 0; i < 200 && xferReq[d] !== want; i++) tick(1);
	endtask : waitReq
	// master releases each channel at its own handshake edge
	task automatic axWrite(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			tick(1);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		resp = bresp;
		bready <= 1'b0;
		tick(1);
	endtask : axWrite
	task automatic axRead(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			tick(1);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
		tick(1);
	endtask : axRead

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic testRegs();
		axRead(REG_CTRL);
		check(rd, 32'h77);
		axRead(8'h0C);
		check(resp, RESP_SLVERR);
		axWrite(REG_CTRL, 32'h0);
		check(resp, RESP_OKAY);
		eventStrobe[0] <= 1'b1;
		chargeAmpResetN[0] <= 1'b0;
		tick(30);
		check(xferReq, 2'h0);
		eventStrobe[0] <= 1'b0;
		chargeAmpResetN[0] <= 1'b1;
		axWrite(REG_CTRL, 32'h77);
		$display("register test done");
	endtask : testRegs
	task automatic testVeto();
		startDisc[0] <= 1'b1;
		upperLevelN[0] <= 1'b0;
		tick(6);
		slowValidN[0] <= 1'b0;
		tick(6);
		slowValidN[0] <= 1'b1;
		startDisc[0] <= 1'b0;
		upperLevelN[0] <= 1'b1;
		axRead(REG_STAT);
		check(rd, 32'h0C);
		eventStrobe[0] <= 1'b1;
		tick(20);
		check(xferReq[0], 1'b0);
		axRead(REG_STAT);
		check(rd, 32'h0);
		eventStrobe[0] <= 1'b0;
		$display("veto test done");
	endtask : testVeto
	task automatic testEnergy();
		startDisc[0] <= 1'b1;
		tick(6);
		check(adcNapCtl[0], 1'b1);
		startDisc[0] <= 1'b0;
		eventStrobe[0] <= 1'b1;
		waitReq(0, 1'b1);
		check(cycleType[0], CYC_EVENT);
		check(eventTime[0], TS_W'(timeStamp - 10'h001));
		check(eventEnergy[0], (13'h0128 ^ 13'h0FFF));
		check(adcNapCtl[0], 1'b0);
		eventStrobe[0] <= 1'b0;
		waitReq(0, 1'b0);
		$display("energy test done");
	endtask : testEnergy
	task automatic testBusy();
		lag <= 8'h40;
		eventStrobe[0] <= 1'b1;
		waitReq(0, 1'b1);
		eventStrobe[0] <= 1'b0;
		tick(4);
		eventStrobe[0] <= 1'b1;
		tick(6);
		check(busyWait[0], 1'b1);
		eventStrobe[0] <= 1'b0;
		waitReq(0, 1'b0);
		tick(2);
		check(busyWait[0], 1'b0);
		tick(10);
		check(xferReq[0], 1'b0);
		lag <= 8'h14;
		$display("busy test done");
	endtask : testBusy
	task automatic testPriority();
		eventStrobe[0] <= 1'b1;
		chargeAmpResetN[0] <= 1'b0;
		overLimitN[0] <= 1'b0;
		for (int k = 1; k <= 3; k++) begin
			waitReq(0, 1'b1);
			check(cycleType[0], k);
			if (k > 1) check(serviceTime[0], TS_W'(timeStamp - 10'h001));
			waitReq(0, 1'b0);
		end
		eventStrobe[0] <= 1'b0;
		chargeAmpResetN[0] <= 1'b1;
		overLimitN[0] <= 1'b1;
		$display("priority test done");
	endtask : testPriority
	// rear front end live for 4000 cycles, exactly 100 microticks
	task automatic testNibble();
		logic [3:0] expNib [4] = '{4'h9, 4'h4, 4'h4, 4'h0};  // 100 is 9'b001_100_100
		frontEndLive[1] <= 1'b1;
		tick(4000);
		frontEndLive[1] <= 1'b0;
		tick(21000 - cycles);
		for (int k = 0; k < 4; k++) begin
			eventStrobe[1] <= 1'b1;
			waitReq(1, 1'b1);
			tick(1);
			check(livetimeNibble[1], expNib[k]);
			eventStrobe[1] <= 1'b0;
			waitReq(1, 1'b0);
			tick(4);
		end
		$display("nibble test done");
	endtask : testNibble
	// first second tick captures upper counter bits, still zero this early
	task automatic testSecond();
		tick(41100 - cycles);
		axRead(REG_LIVE);
		check(rd, 32'h0);
		$display("second test done");
	endtask : testSecond

	task automatic conclude();
		$display("checks %0d errors %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude

	initial begin
		{awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
		wstrb = 4'hF;
		lag = 8'h14;
		frontEndLive = 2'b01; // rear dead except for the nibble window
		{startDisc, eventStrobe} = '0;
		{chargeAmpResetN, overLimitN, slowValidN, upperLevelN} = '1;
		adcData = {13'h0000, 13'h0123};
		ditherOffset = {6'h00, 6'h05};
		tick(4);
		resetn <= 1'b1;
		tick(4);
		testRegs();
		testVeto();
		testEnergy();
		testBusy();
		testPriority();
		testNibble();
		testSecond();
		conclude();
	end
endmodule : detector_event_livetime_tb_top
